// >>> rtl/rsc_defs.svh
// Constants of the routing switch controller: timing, field positions,
// reset values and the command characters.
// Assumes the including file defines nothing with the RSC_ prefix.
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// Clock and timing
`define RSC_CLK_PERIOD_NS 5
`define RSC_POLL_TMO_NS 100000
`define RSC_REF_LOSS_NS 50000000

// Matrix limits
`define RSC_MAX_PORTS 8'h80
`define RSC_RANGE_STEP 8'h10
`define RSC_LEVELS_LOW 4'h4
`define RSC_LEVELS_HIGH 4'h8
`define RSC_XPT_RESET_IN 7'h00

// Configuration bank fields
`define RSC_DIP_BAUD_LSB 0
`define RSC_DIP_IN_LSB 3
`define RSC_DIP_OUT_LSB 6
`define RSC_DIP_ADDR_LSB 9
`define RSC_DIP_LVL8_BIT 11
`define RSC_OPT_ALPHA_BIT 0
`define RSC_OPT_HSHAKE_BIT 1
`define RSC_OPT_SCAN_BIT 2

// Characters
`define RSC_CH_CR 8'h0D
`define RSC_CH_CTRL_N 8'h0E
`define RSC_CH_CTRL_Y 8'h19
`define RSC_CH_SPACE 8'h20
`define RSC_CH_QUEST 8'h3F
`define RSC_CH_A 8'h41
`define RSC_CH_H 8'h48
`define RSC_CH_I 8'h49
`define RSC_CH_K 8'h4B
`define RSC_CH_O 8'h4F
`define RSC_CH_0 8'h30
`define RSC_CH_9 8'h39
`define RSC_CH_LA 8'h61
`define RSC_CH_LZ 8'h7A
`define RSC_CASE_BIT 8'h20

`endif

// >>> rtl/rsc_pkg.sv
// Types shared by the routing switch controller modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package rsc_pkg;
  typedef logic [2:0] rsc_lvl_t;   // Control level 0..7 (levels 1..8)
  typedef logic [6:0] rsc_port_t;  // Port number minus one
  typedef enum logic [1:0] {FLD_NONE, FLD_ALL, FLD_LVL, FLD_OUT} rsc_fld_t;
  typedef enum logic [2:0] {PS_COLLECT, PS_TAKE, PS_EXEC, PS_RESP_A, PS_RESP_B} rsc_pst_t;
  typedef enum logic [1:0] {XS_IDLE, XS_WAIT_VI, XS_WRITE, XS_UPD} rsc_xst_t;
  typedef enum logic [1:0] {PL_ISSUE, PL_WAIT, PL_REQ, PL_RUN} rsc_plst_t;
endpackage : rsc_pkg
`default_nettype wire

// >>> rtl/rsc_xpt_if.sv
// Carrier between the controller core and its crosspoint store.
// Assumes both ends share core_clk_i.
`default_nettype none
interface rsc_xpt_if;
  logic wr_en;                 // Write one crosspoint this cycle
  rsc_pkg::rsc_lvl_t wr_level;
  rsc_pkg::rsc_port_t wr_out;
  rsc_pkg::rsc_port_t wr_in;
  rsc_pkg::rsc_lvl_t rd_level; // Combinational read address
  rsc_pkg::rsc_port_t rd_out;
  rsc_pkg::rsc_port_t rd_in;
  logic busy;                  // Post-reset clearing sweep running
  modport store(input wr_en, wr_level, wr_out, wr_in, rd_level, rd_out, output rd_in, busy);
  modport ctrl(output wr_en, wr_level, wr_out, wr_in, rd_level, rd_out, input rd_in, busy);
endinterface : rsc_xpt_if
`default_nettype wire

// >>> rtl/rsc_xpt_store.sv
// Crosspoint store: one source per output per level, driving the frame bus.
// Assumes the controller waits for busy to fall before writing.
`include "rsc_defs.svh"
`default_nettype none
module rsc_xpt_store #(
  parameter int unsigned LEVELS = 8,
  parameter int unsigned OUTS = 128
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Controller side
  rsc_xpt_if.store xpt,
  // Frame bus
  output logic frame_we_o,
  output rsc_pkg::rsc_lvl_t frame_level_o,
  output rsc_pkg::rsc_port_t frame_out_o,
  output rsc_pkg::rsc_port_t frame_in_o
);
  localparam int unsigned DEPTH = LEVELS * OUTS;

  // The index is a plain concatenation, so the sizes are fixed
  if (LEVELS != 8 || OUTS != 128) begin : g_bad_size
    $error("store is sized for 8 levels of 128 outputs");
  end

  logic [6:0] mem [DEPTH];     // Source per level and output
  logic [10:0] clr_q, clr_d;   // Clearing sweep position, top bit = done
  logic we_q, we_d;
  rsc_pkg::rsc_lvl_t lvl_q, lvl_d;
  rsc_pkg::rsc_port_t out_q, out_d;
  rsc_pkg::rsc_port_t in_q, in_d;

  // Level and output pack straight into an address
  function automatic logic [9:0] xpt_index(input rsc_pkg::rsc_lvl_t l, input rsc_pkg::rsc_port_t o);
    xpt_index = {l, o};
  endfunction : xpt_index

  assign xpt.busy = !clr_q[10];
  assign xpt.rd_in = mem[xpt_index(xpt.rd_level, xpt.rd_out)];

  // Sweep every crosspoint to input 1 after reset, else pass writes on
  always_comb begin
    clr_d = clr_q;
    we_d = 1'b0;
    lvl_d = lvl_q;
    out_d = out_q;
    in_d = in_q;
    if (!clr_q[10]) begin
      we_d = 1'b1;
      lvl_d = clr_q[9:7];
      out_d = clr_q[6:0];
      in_d = `RSC_XPT_RESET_IN;
      clr_d = clr_q + 11'h001;
    end else if (xpt.wr_en) begin
      we_d = 1'b1;
      lvl_d = xpt.wr_level;
      out_d = xpt.wr_out;
      in_d = xpt.wr_in;
    end
  end

  // Registers of the sweep and the frame bus
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      clr_q <= 11'h000;
      we_q <= 1'b0;
      lvl_q <= 3'h0;
      out_q <= 7'h00;
      in_q <= 7'h00;
    end else begin
      clr_q <= clr_d;
      we_q <= we_d;
      lvl_q <= lvl_d;
      out_q <= out_d;
      in_q <= in_d;
    end
  end

  // Array has no reset; the sweep above fills it
  always_ff @(posedge core_clk_i) begin
    if (we_d) begin
      mem[xpt_index(lvl_d, out_d)] <= in_d;
    end
  end

  assign frame_we_o = we_q;
  assign frame_level_o = lvl_q;
  assign frame_out_o = out_q;
  assign frame_in_o = in_q;
endmodule : rsc_xpt_store
`default_nettype wire

// >>> rtl/rsc_top.sv
// Routing switch controller: serial command parser, panel poller,
// switch executor with vertical-interval timing, crosspoint store.
// Assumes a UART delivers bytes on core_clk_i, panel line transceivers
// deliver decoded replies on core_clk_i, switch banks and ref are pins.
`include "rsc_defs.svh"
`default_nettype none
module rsc_top #(
  parameter int unsigned POLL_TMO_CYC = `RSC_POLL_TMO_NS / `RSC_CLK_PERIOD_NS,
  parameter int unsigned REF_LOSS_CYC = `RSC_REF_LOSS_NS / `RSC_CLK_PERIOD_NS
) (
  // Clock and pushbutton reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Serial byte stream
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  // Panel line ports one and two, decoded replies
  input wire logic [1:0] pnl_rsp_valid_i,
  input wire logic [1:0][7:0] pnl_rsp_mask_i,
  input wire logic [1:0][7:0] pnl_rsp_in_i,
  input wire logic [1:0][7:0] pnl_rsp_out_i,
  // Poll and update, sent on both ports
  output logic poll_valid_o,
  output logic [5:0] poll_addr_o,
  output logic upd_valid_o,
  output rsc_pkg::rsc_lvl_t upd_level_o,
  output rsc_pkg::rsc_port_t upd_out_o,
  output rsc_pkg::rsc_port_t upd_in_o,
  // Reference and switch banks
  input wire logic ref_i,
  input wire logic [11:0] configuration_dip_bank_i,
  input wire logic [3:0] option_switch_bank_i,
  // Configuration and status outputs
  output logic [2:0] baud_sel_o,
  output logic [1:0] proto_addr_o,
  output logic alpha_mode_o,
  output logic handshake_en_o,
  output logic ref_present_o,
  output logic quiet_o,
  output logic tables_erase_o,
  // Frame bus
  output logic frame_we_o,
  output rsc_pkg::rsc_lvl_t frame_level_o,
  output rsc_pkg::rsc_port_t frame_out_o,
  output rsc_pkg::rsc_port_t frame_in_o
);
  if (POLL_TMO_CYC == 0 || REF_LOSS_CYC == 0) begin : g_bad_count
    $error("timeout counts must be nonzero");
  end

  rsc_xpt_if xpt();

  rsc_xpt_store #(.LEVELS(8), .OUTS(128)) u_store (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .xpt(xpt.store),
    .frame_we_o(frame_we_o),
    .frame_level_o(frame_level_o),
    .frame_out_o(frame_out_o),
    .frame_in_o(frame_in_o)
  );

  // Fold lower case onto upper case
  function automatic logic [7:0] upcase(input logic [7:0] c);
    upcase = (c >= `RSC_CH_LA && c <= `RSC_CH_LZ) ? (c & ~`RSC_CASE_BIT) : c;
  endfunction : upcase

  // Number is 1..max
  function automatic logic in_range(input logic [7:0] n, input logic [7:0] max);
    in_range = (n != 8'h00) && (n <= max);
  endfunction : in_range

  // Range code 0..7 gives 16..128 ports
  function automatic logic [7:0] range_of(input logic [2:0] code);
    range_of = 8'({5'h00, code} + 8'h01) * `RSC_RANGE_STEP;
  endfunction : range_of

  // Two-flop synchronisers for the pins
  logic [11:0] dip_s1_q, dip_s2_q;
  logic [3:0] opt_s1_q, opt_s2_q;
  logic ref_s1_q, ref_s2_q, ref_s3_q;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dip_s1_q <= 12'h000;
      dip_s2_q <= 12'h000;
      opt_s1_q <= 4'h0;
      opt_s2_q <= 4'h0;
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
    end else begin
      dip_s1_q <= configuration_dip_bank_i;
      dip_s2_q <= dip_s1_q;
      opt_s1_q <= option_switch_bank_i;
      opt_s2_q <= opt_s1_q;
      ref_s1_q <= ref_i;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
    end
  end

  // Decoded configuration, live from the banks
  logic [7:0] n_in, n_out;
  logic [3:0] n_lv;
  logic [7:0] lvl_all;
  logic scan_en;
  assign n_in = range_of(dip_s2_q[`RSC_DIP_IN_LSB +: 3]);
  assign n_out = range_of(dip_s2_q[`RSC_DIP_OUT_LSB +: 3]);
  assign n_lv = dip_s2_q[`RSC_DIP_LVL8_BIT] ? `RSC_LEVELS_HIGH : `RSC_LEVELS_LOW;
  assign lvl_all = dip_s2_q[`RSC_DIP_LVL8_BIT] ? 8'hFF : 8'h0F;
  assign baud_sel_o = dip_s2_q[`RSC_DIP_BAUD_LSB +: 3];
  assign proto_addr_o = dip_s2_q[`RSC_DIP_ADDR_LSB +: 2];
  assign alpha_mode_o = opt_s2_q[`RSC_OPT_ALPHA_BIT];
  assign handshake_en_o = opt_s2_q[`RSC_OPT_HSHAKE_BIT];
  assign scan_en = opt_s2_q[`RSC_OPT_SCAN_BIT];
  // Salvo and restriction memories sit outside; they clear during the sweep
  assign tables_erase_o = xpt.busy;

  // Reference watch: a rising edge marks the vertical interval
  logic vi_edge;
  logic [31:0] ref_cnt_q, ref_cnt_d;
  logic ref_ok_q, ref_ok_d;
  assign vi_edge = ref_s2_q && !ref_s3_q;
  always_comb begin
    ref_cnt_d = vi_edge ? 32'h0000_0000 : ref_cnt_q;
    ref_ok_d = ref_ok_q;
    if (vi_edge) begin
      ref_ok_d = 1'b1;
    end else if (ref_cnt_q >= REF_LOSS_CYC - 1) begin
      ref_ok_d = 1'b0;                  // Reference lost
    end else begin
      ref_cnt_d = ref_cnt_q + 32'h0000_0001;
    end
  end
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ref_cnt_q <= 32'h0000_0000;
      ref_ok_q <= 1'b0;
    end else begin
      ref_cnt_q <= ref_cnt_d;
      ref_ok_q <= ref_ok_d;
    end
  end
  assign ref_present_o = ref_ok_q;

  // Executor state
  rsc_pkg::rsc_xst_t xs_q, xs_d;
  logic [7:0] xmask_q, xmask_d;
  logic [7:0][6:0] xins_q, xins_d;
  rsc_pkg::rsc_port_t xout_q, xout_d;
  rsc_pkg::rsc_lvl_t xlvl_q, xlvl_d;
  logic xpnl_q, xpnl_d;
  logic xdone, go_ser, go_pnl;
  logic upd_v_d;
  rsc_pkg::rsc_port_t upd_in_d;

  // Parser state
  rsc_pkg::rsc_pst_t ps_q, ps_d;
  rsc_pkg::rsc_fld_t kind_q, kind_d;
  rsc_pkg::rsc_lvl_t flvl_q, flvl_d;
  logic [7:0] num_q, num_d;
  logic dig_q, dig_d, err_q, err_d, hout_q, hout_d, ok_q, ok_d, quiet_q, quiet_d;
  logic [7:0] mask_q, mask_d;
  logic [7:0][6:0] ins_q, ins_d;
  rsc_pkg::rsc_port_t out_q, out_d;
  logic [7:0] tx_q, tx_d;

  // Poller state
  rsc_pkg::rsc_plst_t pl_q, pl_d;
  logic [5:0] paddr_q, paddr_d;
  logic [31:0] pcnt_q, pcnt_d;
  logic [7:0] pmask_q, pmask_d;
  rsc_pkg::rsc_port_t pin_q, pin_d, pout_q, pout_d;
  logic poll_v_d;

  // Serial always takes the executor before a panel
  assign go_ser = (xs_q == rsc_pkg::XS_IDLE) && !xpt.busy && (ps_q == rsc_pkg::PS_TAKE);
  assign go_pnl = (xs_q == rsc_pkg::XS_IDLE) && !xpt.busy && (pl_q == rsc_pkg::PL_REQ) && !go_ser;

  // Command parser: one byte per cycle while collecting
  logic [7:0] c;
  logic [11:0] acc;
  logic cerr;
  always_comb begin
    ps_d = ps_q; kind_d = kind_q; flvl_d = flvl_q; num_d = num_q; dig_d = dig_q;
    err_d = err_q; hout_d = hout_q; ok_d = ok_q; quiet_d = quiet_q;
    mask_d = mask_q; ins_d = ins_q; out_d = out_q; tx_d = tx_q;
    c = upcase(rx_data_i);
    acc = 12'(num_q) * 12'd10 + 12'(c - `RSC_CH_0);
    cerr = 1'b0;
    case (ps_q)
      rsc_pkg::PS_COLLECT: begin
        if (rx_valid_i) begin
          if (c == `RSC_CH_CTRL_N) begin
            quiet_d = 1'b1;
          end else if (c == `RSC_CH_CTRL_Y) begin
            quiet_d = 1'b0;
          end else if (c == `RSC_CH_SPACE) begin
            // Clear entry; also why embedded spaces cannot separate fields
            kind_d = rsc_pkg::FLD_NONE; dig_d = 1'b0; num_d = 8'h00;
            err_d = 1'b0; hout_d = 1'b0; mask_d = 8'h00;
          end else if (c >= `RSC_CH_0 && c <= `RSC_CH_9) begin
            err_d = err_q || (kind_q == rsc_pkg::FLD_NONE);
            num_d = (acc > 12'h0FF) ? 8'hFF : acc[7:0];                    // Leading zeros fold away
            dig_d = 1'b1;
          end else if (c == `RSC_CH_I || c == `RSC_CH_O || c == `RSC_CH_CR ||
                       (c >= `RSC_CH_A && c <= `RSC_CH_H)) begin
            // Close the field just typed
            case (kind_q)
              rsc_pkg::FLD_ALL: begin
                cerr = !dig_q || !in_range(num_q, n_in);
                mask_d = lvl_all;
                for (int i = 0; i < 8; i++) ins_d[i] = 7'(num_q - 8'h01);
              end
              rsc_pkg::FLD_LVL: begin
                cerr = !dig_q || !in_range(num_q, n_in) || (4'(flvl_q) >= n_lv);
                mask_d[flvl_q] = 1'b1;
                ins_d[flvl_q] = 7'(num_q - 8'h01);
              end
              rsc_pkg::FLD_OUT: begin
                cerr = !dig_q || !in_range(num_q, n_out);
                out_d = 7'(num_q - 8'h01);
                hout_d = 1'b1;
              end
              default: cerr = dig_q;
            endcase
            err_d = err_q || cerr;
            num_d = 8'h00;
            dig_d = 1'b0;
            flvl_d = 3'(c - `RSC_CH_A);
            if (c == `RSC_CH_I) begin
              kind_d = rsc_pkg::FLD_ALL;
            end else if (c == `RSC_CH_O) begin
              kind_d = rsc_pkg::FLD_OUT;
            end else if (c == `RSC_CH_CR) begin
              // Return ends the command; any held error shows now
              ok_d = !err_d && hout_d && (mask_d != 8'h00);
              ps_d = ok_d ? rsc_pkg::PS_TAKE : rsc_pkg::PS_RESP_A;
              tx_d = ok_d ? `RSC_CH_O : `RSC_CH_QUEST;
              kind_d = rsc_pkg::FLD_NONE;
              err_d = 1'b0;
              hout_d = 1'b0;
            end else begin
              kind_d = rsc_pkg::FLD_LVL;
            end
          end else begin
            err_d = 1'b1;
          end
        end
      end
      rsc_pkg::PS_TAKE: begin
        if (go_ser) begin
          ps_d = rsc_pkg::PS_EXEC;
          mask_d = 8'h00;
        end
      end
      rsc_pkg::PS_EXEC: begin
        if (xdone && !xpnl_q) begin
          ps_d = rsc_pkg::PS_RESP_A;
        end
      end
      rsc_pkg::PS_RESP_A: begin
        // Muted answers are dropped, never queued
        if (quiet_q) begin
          ps_d = rsc_pkg::PS_COLLECT;
          mask_d = 8'h00;
        end else if (tx_ready_i) begin
          ps_d = ok_q ? rsc_pkg::PS_RESP_B : rsc_pkg::PS_COLLECT;
          tx_d = `RSC_CH_K;
          mask_d = 8'h00;
        end
      end
      default: begin
        if (quiet_q || tx_ready_i) begin
          ps_d = rsc_pkg::PS_COLLECT;
        end
      end
    endcase
  end
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ps_q <= rsc_pkg::PS_COLLECT; kind_q <= rsc_pkg::FLD_NONE; flvl_q <= 3'h0;
      num_q <= 8'h00; dig_q <= 1'b0; err_q <= 1'b0; hout_q <= 1'b0; ok_q <= 1'b0;
      quiet_q <= 1'b0; mask_q <= 8'h00; ins_q <= '0; out_q <= 7'h00; tx_q <= 8'h00;
    end else begin
      ps_q <= ps_d; kind_q <= kind_d; flvl_q <= flvl_d;
      num_q <= num_d; dig_q <= dig_d; err_q <= err_d; hout_q <= hout_d; ok_q <= ok_d;
      quiet_q <= quiet_d; mask_q <= mask_d; ins_q <= ins_d; out_q <= out_d; tx_q <= tx_d;
    end
  end
  assign rx_ready_o = (ps_q == rsc_pkg::PS_COLLECT);
  assign tx_valid_o = !quiet_q && (ps_q == rsc_pkg::PS_RESP_A || ps_q == rsc_pkg::PS_RESP_B);
  assign tx_data_o = tx_q;
  assign quiet_o = quiet_q;

  // Panel poller; replies from either port go through one path
  logic rsp_v;
  logic [1:0] rsp_sel;
  logic rsp_good;
  always_comb begin
    pl_d = pl_q; paddr_d = paddr_q; pcnt_d = pcnt_q; poll_v_d = 1'b0;
    pmask_d = pmask_q; pin_d = pin_q; pout_d = pout_q;
    rsp_v = |pnl_rsp_valid_i;
    rsp_sel = pnl_rsp_valid_i[0] ? 2'h0 : 2'h1;
    rsp_good = ((pnl_rsp_mask_i[rsp_sel[0]] & lvl_all) != 8'h00) &&
               in_range(pnl_rsp_in_i[rsp_sel[0]], n_in) && in_range(pnl_rsp_out_i[rsp_sel[0]], n_out);
    case (pl_q)
      rsc_pkg::PL_ISSUE: begin
        if (scan_en) begin
          poll_v_d = 1'b1;
          pcnt_d = 32'h0000_0000;
          pl_d = rsc_pkg::PL_WAIT;
        end
      end
      rsc_pkg::PL_WAIT: begin
        pcnt_d = pcnt_q + 32'h0000_0001;
        if (rsp_v && rsp_good) begin
          pmask_d = pnl_rsp_mask_i[rsp_sel[0]] & lvl_all;
          pin_d = 7'(pnl_rsp_in_i[rsp_sel[0]] - 8'h01);
          pout_d = 7'(pnl_rsp_out_i[rsp_sel[0]] - 8'h01);
          pl_d = rsc_pkg::PL_REQ;
        end else if (rsp_v || pcnt_q >= POLL_TMO_CYC - 1) begin
          paddr_d = paddr_q + 6'h01;
          pl_d = rsc_pkg::PL_ISSUE;
        end
      end
      rsc_pkg::PL_REQ: begin
        if (go_pnl) pl_d = rsc_pkg::PL_RUN;
      end
      default: begin
        if (xdone && xpnl_q) begin
          paddr_d = paddr_q + 6'h01;
          pl_d = rsc_pkg::PL_ISSUE;
        end
      end
    endcase
  end
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pl_q <= rsc_pkg::PL_ISSUE; paddr_q <= 6'h00; pcnt_q <= 32'h0000_0000;
      pmask_q <= 8'h00; pin_q <= 7'h00; pout_q <= 7'h00; poll_valid_o <= 1'b0;
    end else begin
      pl_q <= pl_d; paddr_q <= paddr_d; pcnt_q <= pcnt_d;
      pmask_q <= pmask_d; pin_q <= pin_d; pout_q <= pout_d; poll_valid_o <= poll_v_d;
    end
  end
  assign poll_addr_o = paddr_q;

  // Executor: wait for the interval, write levels, then broadcast
  always_comb begin
    xs_d = xs_q; xmask_d = xmask_q; xins_d = xins_q; xout_d = xout_q;
    xlvl_d = xlvl_q; xpnl_d = xpnl_q; xdone = 1'b0; upd_v_d = 1'b0;
    upd_in_d = xpt.rd_in;
    xpt.wr_en = 1'b0;
    xpt.wr_level = xlvl_q;
    xpt.wr_out = xout_q;
    xpt.wr_in = xins_q[xlvl_q];
    xpt.rd_level = xlvl_q;
    xpt.rd_out = xout_q;
    case (xs_q)
      rsc_pkg::XS_IDLE: begin
        if (go_ser || go_pnl) begin
          xpnl_d = go_pnl;
          xmask_d = go_ser ? mask_q : pmask_q;
          xout_d = go_ser ? out_q : pout_q;
          for (int i = 0; i < 8; i++) xins_d[i] = go_ser ? ins_q[i] : pin_q;
          xlvl_d = 3'h0;
          xs_d = ref_ok_q ? rsc_pkg::XS_WAIT_VI : rsc_pkg::XS_WRITE;
        end
      end
      rsc_pkg::XS_WAIT_VI: begin
        // A lost reference must not stall the switch forever
        if (vi_edge || !ref_ok_q) xs_d = rsc_pkg::XS_WRITE;
      end
      rsc_pkg::XS_WRITE: begin
        xpt.wr_en = xmask_q[xlvl_q];
        xlvl_d = xlvl_q + 3'h1;
        if (xlvl_q == 3'h7) xs_d = rsc_pkg::XS_UPD;
      end
      default: begin
        upd_v_d = 1'b1;
        xlvl_d = xlvl_q + 3'h1;
        if (4'(xlvl_q) == n_lv - 4'h1) begin
          xs_d = rsc_pkg::XS_IDLE;
          xdone = 1'b1;
        end
      end
    endcase
  end
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      xs_q <= rsc_pkg::XS_IDLE; xmask_q <= 8'h00; xins_q <= '0; xout_q <= 7'h00;
      xlvl_q <= 3'h0; xpnl_q <= 1'b0;
      upd_valid_o <= 1'b0; upd_level_o <= 3'h0; upd_out_o <= 7'h00; upd_in_o <= 7'h00;
    end else begin
      xs_q <= xs_d; xmask_q <= xmask_d; xins_q <= xins_d; xout_q <= xout_d;
      xlvl_q <= xlvl_d; xpnl_q <= xpnl_d;
      upd_valid_o <= upd_v_d; upd_level_o <= xlvl_q; upd_out_o <= xout_q; upd_in_o <= upd_in_d;
    end
  end
endmodule : rsc_top
`default_nettype wire

// >>> bench/rsc_top_properties.sv
// Checker of the controller's port timing, bound onto rsc_top.
// Assumes one clock domain and the active-high reset.
`default_nettype none
module rsc_top_properties (
  input wire logic core_clk_i, reset_i, rx_ready_o, tx_valid_o, tx_ready_i, poll_valid_o,
  input wire logic quiet_o, tables_erase_o, frame_we_o,
  input wire logic [7:0] tx_data_o,
  input wire rsc_pkg::rsc_port_t frame_in_o,
  input wire logic [2:0] baud_sel_o,
  input wire logic [11:0] configuration_dip_bank_i
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // First half of the completion answer taken by the host
  sequence s_o_taken;
    tx_valid_o && tx_ready_i && tx_data_o == 8'h4F;
  endsequence
  a_poll_pulse: assert property (poll_valid_o |=> !poll_valid_o) else $error("poll too long");
  a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("tx dropped");
  a_ok_pair: assert property (s_o_taken |-> ##[1:2] tx_valid_o && tx_data_o == 8'h4B) else $error("no K");
  a_tx_chars: assert property (tx_valid_o |-> tx_data_o inside {8'h4F, 8'h4B, 8'h3F}) else $error("bad char");
  a_quiet_mute: assert property (quiet_o && $past(quiet_o) |-> !tx_valid_o) else $error("muted tx");
  a_resp_closed: assert property (tx_valid_o |-> !rx_ready_o) else $error("rx open");
  a_sweep_input: assert property (tables_erase_o && frame_we_o |-> frame_in_o == 7'h00) else $error("sweep");
  a_cfg_sync: assert property (!tables_erase_o |-> baud_sel_o == $past(configuration_dip_bank_i[2:0], 2))
    else $error("baud");
endmodule : rsc_top_properties
bind rsc_top rsc_top_properties u_rsc_top_properties (.core_clk_i(core_clk_i), .reset_i(reset_i),
  .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .poll_valid_o(poll_valid_o),
  .quiet_o(quiet_o), .tables_erase_o(tables_erase_o), .frame_we_o(frame_we_o), .tx_data_o(tx_data_o),
  .frame_in_o(frame_in_o), .baud_sel_o(baud_sel_o), .configuration_dip_bank_i(configuration_dip_bank_i));
`default_nettype wire

// >>> bench/rsc_panel_model.sv
// Remote panel model: answers a poll of its own address with one request.
// Assumes polls arrive as one-cycle strobes on core_clk_i.
`default_nettype none
module rsc_panel_model #(parameter logic [5:0] ADDR = 6'h00, parameter logic [7:0] IN = 8'h01) (
  input wire logic core_clk_i, en_i, poll_valid_i,
  input wire logic [5:0] poll_addr_i,
  output logic rsp_valid_o = 1'b0,
  output logic [7:0] rsp_mask_o, rsp_in_o, rsp_out_o
);
  logic hit_q = 1'b0; // Own poll seen
  // Lines carry junk outside a reply, never the last value
  assign rsp_mask_o = rsp_valid_o ? 8'h01 : 8'hFE;
  assign rsp_in_o = rsp_valid_o ? IN : ~IN;
  assign rsp_out_o = rsp_valid_o ? IN + 8'h0A : ~IN;
  // Reply two cycles after a poll of this address only
  always @(posedge core_clk_i) begin
    hit_q <= en_i && poll_valid_i && poll_addr_i == ADDR;
    rsp_valid_o <= hit_q;
  end
endmodule : rsc_panel_model
`default_nettype wire

// >>> bench/tb_rsc_top.sv
// Bench of the routing switch controller: serial, reference and panel cases.
// Assumes the design files and the panel model are compiled first.
`default_nettype none
module tb_rsc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, rx_v = 0, ref_r = 0, en = 0, tr = 1;
  logic [7:0] rx_d = 8'h00;
  logic [11:0] dip = 12'hFFF; // Eight levels, full ranges
  logic [3:0] opt = 4'h4; // Panel scanning on
  wire logic [1:0] pv;
  wire logic [1:0][7:0] pm, pi, po;
  logic rx_r, tx_v, poll_v, upd_v, we, qt, er, rp, al, hs;
  logic [7:0] tx_d;
  logic [5:0] pa;
  rsc_pkg::rsc_lvl_t fl, ul;
  rsc_pkg::rsc_port_t fo, fi, uo, ui;
  logic [6:0] xp [8][128]; // Crosspoints seen on the frame bus
  byte q[$];
  int n_errors = 0, n_tests = 0, cyc = 0, nw = 0, nu = 0, i;
  rsc_top #(.POLL_TMO_CYC(20), .REF_LOSS_CYC(200)) u_rsc_top (.core_clk_i(clk), .reset_i(rst),
    .rx_data_i(rx_d), .rx_valid_i(rx_v), .rx_ready_o(rx_r), .tx_data_o(tx_d), .tx_valid_o(tx_v),
    .tx_ready_i(tr), .pnl_rsp_valid_i(pv), .pnl_rsp_mask_i(pm), .pnl_rsp_in_i(pi), .pnl_rsp_out_i(po),
    .poll_valid_o(poll_v), .poll_addr_o(pa), .upd_valid_o(upd_v), .upd_level_o(ul), .upd_out_o(uo),
    .upd_in_o(ui), .ref_i(ref_r), .configuration_dip_bank_i(dip), .option_switch_bank_i(opt),
    .baud_sel_o(), .proto_addr_o(), .alpha_mode_o(al), .handshake_en_o(hs), .ref_present_o(rp), .quiet_o(qt),
    .tables_erase_o(er), .frame_we_o(we), .frame_level_o(fl), .frame_out_o(fo), .frame_in_o(fi));
  rsc_panel_model #(.ADDR(6'h03), .IN(8'h0A)) u_rsc_panel_model_a (.core_clk_i(clk), .en_i(en),
    .poll_valid_i(poll_v), .poll_addr_i(pa), .rsp_valid_o(pv[0]), .rsp_mask_o(pm[0]), .rsp_in_o(pi[0]),
    .rsp_out_o(po[0]));
  rsc_panel_model #(.ADDR(6'h05), .IN(8'h0B)) u_rsc_panel_model_b (.core_clk_i(clk), .en_i(en),
    .poll_valid_i(poll_v), .poll_addr_i(pa), .rsp_valid_o(pv[1]), .rsp_mask_o(pm[1]), .rsp_in_o(pi[1]),
    .rsp_out_o(po[1]));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Monitor: answers taken, frame writes, broadcasts, hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tx_v && tr) q.push_back(tx_d);
    if (we) xp[fl][fo] <= fi;
    if (we) nw <= nw + 1;
    if (upd_v && ul == 3'h0 && uo == 7'd20 && ui == 7'd10) nu <= nu + 1;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  // Sends bytes; each held until an edge that samples ready high
  task automatic send(input string s);
    logic t;
    foreach (s[k]) begin
      rx_d = s[k];
      rx_v = 1;
      do begin t = rx_r; @(posedge clk); #1; end while (t !== 1'b1);
    end
    rx_v = 0;
    @(posedge clk); // Strobe stays low across one edge
    #1;
  endtask : send
  // Waits for the parser to reopen, then compares what was answered
  task automatic fin(input string e);
    for (i = 0; i < 300 && rx_r !== 1'b1; i++) begin @(posedge clk); #1; end
    chk("answer length", e.len(), q.size());
    foreach (e[k]) chk("answer byte", e[k], (k < q.size()) ? q[k] : 8'h00);
    q.delete();
  endtask : fin
  task automatic cmd(input string s, input string e);
    send(s);
    fin(e);
  endtask : cmd
  task automatic tally_and_finish();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 0;
    chk("erase on", 1, er);
    repeat (1030) @(posedge clk);
    #1 chk("sweep writes", 1024, nw);
    chk("erase off", 0, er);
    chk("reset map", 0, xp[7][127]);
    tr = 0;
    send("i5o3\015");
    repeat (30) @(posedge clk);
    #1 tr = 1;
    fin("OK");
    for (int l = 0; l < 8; l++) chk("all levels", 4, xp[l][2]);
    cmd("B7O3\015", "OK");
    chk("breakaway", 6, xp[1][2]);
    chk("other level", 4, xp[0][2]);
    cmd("C9a2O3\015", "OK");
    chk("split c", 8, xp[2][2]);
    chk("split a", 1, xp[0][2]);
    send("IZ1");
    repeat (5) @(posedge clk);
    chk("held error", 0, q.size());
    cmd("\015", "?");
    cmd("I200O1\015", "?");
    send("\016");
    cmd("I1O1\015", "");
    chk("muted", 1, qt);
    send("\031");
    cmd("I2O2\015", "OK");
    ref_r = 1;
    repeat (4) @(posedge clk);
    #1 ref_r = 0;
    chk("ref seen", 1, rp);
    send("I9O9\015");
    repeat (20) @(posedge clk);
    #1 chk("before vi", 0, xp[0][8]);
    ref_r = 1;
    fin("OK");
    chk("at vi", 8, xp[0][8]);
    en = 1;
    for (i = 0; i < 4000 && (xp[0][19] !== 7'd9 || xp[0][20] !== 7'd10); i++) begin @(posedge clk); #1; end
    en = 0;
    repeat (20) @(posedge clk);
    #1 chk("panel one", 9, xp[0][19]);
    chk("panel two", 10, xp[0][20]);
    chk("broadcast", 1, nu);
    dip = 12'h7C7; // Four levels, sixteen inputs
    repeat (4) @(posedge clk);
    #1 cmd("E1O1\015", "?");
    cmd("I17O1\015", "?");
    opt = 4'h3; // Alpha, handshake, scanning off
    repeat (30) @(posedge clk);
    #1 chk("alpha", 1, al);
    chk("handshake", 1, hs);
    i = pa;
    repeat (40) @(posedge clk);
    #1 chk("scan off", i, pa);
    tally_and_finish();
  end
endmodule : tb_rsc_top
`default_nettype wire
